// *** include/servo_cfg_pkg.sv ***
// shared constants for the servo station configuration and overtravel block
package servo_cfg_pkg;
    // ==========================================================
    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int DEBOUNCE_NS = 20000;
    localparam int DEBOUNCE_CYC =
        (DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BOOT_CYC = 3;
    // ==========================================================
    // register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] DIR_OFS = 8'h04;
    localparam logic [7:0] FWD_SEL_OFS = 8'h08;
    localparam logic [7:0] REV_SEL_OFS = 8'h0C;
    localparam logic [7:0] STOP_OFS = 8'h10;
    localparam logic [7:0] ESTOP_OFS = 8'h14;
    localparam logic [7:0] MAXTRQ_OFS = 8'h18;
    localparam logic [7:0] STATUS_OFS = 8'h1C;
    localparam logic [7:0] ACTIVE_OFS = 8'h20;
    // field positions
    localparam int CTRL_RESTART_BIT = 0;
    localparam int DIR_REVERSE_BIT = 0;
    // ==========================================================
    // reset values and codes
    localparam logic [3:0] FWD_SEL_RST = 4'h1;
    localparam logic [3:0] REV_SEL_RST = 4'h2;
    localparam logic [3:0] SEL_IGNORE = 4'h8;
    localparam logic [7:0] STOP_RST = 8'h00;
    localparam logic [3:0] STOP_COAST = 4'h2;
    localparam logic [3:0] DECEL_ZCLAMP = 4'h1;
    localparam logic [3:0] DECEL_COAST = 4'h2;
    localparam logic [9:0] ESTOP_MAX = 10'h320;
    localparam logic [9:0] ESTOP_RST = 10'h320;
    localparam logic [9:0] MAXTRQ_RST = 10'h12C;
    localparam logic [7:0] ADDR_FIRST = 8'h03;
    localparam logic [7:0] ADDR_LAST = 8'hEF;
    localparam logic [5:0] BYTES_16 = 6'h10;
    localparam logic [5:0] BYTES_32 = 6'h20;
    localparam logic [5:0] BYTES_48 = 6'h30;
    // ==========================================================
    typedef enum logic [5:0] {
        ST_RUN = 6'h01,
        ST_DB_STOP = 6'h02,
        ST_COAST_STOP = 6'h04,
        ST_DECEL = 6'h08,
        ST_ZCLAMP = 6'h10,
        ST_COAST_HOLD = 6'h20
    } stop_state_t;
endpackage : servo_cfg_pkg

// *** core/servo_station_config_overtravel_stop.sv ***
// station switches, direction, overtravel gating and stop sequencing
`timescale 1ns/1ps
// Notes on behaviour
// - station address is high switch digit then low digit; factory 03H.
// - DIP 1,2 give 16/32/48 bytes; both on reserved; factory 48.
// - switch settings are captured only once after power-up.
// - reverse setting flips motor travel, encoder output untouched.
// - standard direction treats counterclockwise as forward.
// - forward limit on allows forward run; off is forward overtravel.
// - reverse limit on allows reverse run; off is reverse overtravel.
// - opposite-direction references still accepted during overtravel.
// - forward limit select 8 ignores the input; applied after restart.
// - reverse limit select 8 ignores the input; applied after restart.
// - stop low digit 0/1 brakes dynamically, 2 coasts; then coast.
// - second digit 1: decelerate then zero clamp; 2: decelerate, coast.
// - zero clamp holds a position loop around reference zero.
// - torque control never decelerates; brake or coast, then coast.
// - emergency torque 0-800 percent, default 800, applied at once.
// - applied emergency torque never exceeds motor maximum torque.
module servo_station_config_overtravel_stop (
    input wire logic ref_clk, // system clock
    input wire logic arst_n, // asynchronous reset
    input wire logic wb_cyc_i, // wishbone cycle
    input wire logic wb_stb_i, // wishbone strobe
    input wire logic wb_we_i, // wishbone write
    input wire logic [7:0] wb_adr_i, // byte address
    input wire logic [3:0] wb_sel_i, // byte lanes
    input wire logic [31:0] wb_dat_i, // write data
    output logic [31:0] wb_dat_o, // read data
    output logic wb_ack_o, // acknowledge
    input wire logic [3:0] addr_high_switch, // rotary, high digit
    input wire logic [3:0] addr_low_switch, // rotary, low digit
    input wire logic [3:0] link_option_dip, // dip positions 4..1
    input wire logic fwd_limit_in, // forward limit, on = allowed
    input wire logic rev_limit_in, // reverse limit, on = allowed
    input wire logic enc_a_in, // encoder phase a
    input wire logic enc_b_in, // encoder phase b
    input wire logic ref_active, // reference asks for motion
    input wire logic ref_fwd, // reference direction forward
    input wire logic torque_mode, // drive is under torque control
    input wire logic motor_stopped, // speed has reached zero
    output logic [7:0] station_addr, // captured station address
    output logic station_valid, // address in usable range
    output logic [5:0] xfer_bytes, // transmission byte count
    output logic xfer_valid, // byte count not reserved
    output logic motor_ccw, // commanded rotation counterclockwise
    output logic motion_en, // reference may drive the motor
    output logic fwd_overtravel, // forward overtravel active
    output logic rev_overtravel, // reverse overtravel active
    output logic dyn_brake_on, // dynamic braking active
    output logic coast_on, // power stage off, motor coasting
    output logic decel_on, // decelerating at emergency torque
    output logic [9:0] decel_torque, // torque limit percent while decel
    output logic zero_clamp_on, // position loop on zero reference
    output logic enc_a_out, // encoder pulse out phase a
    output logic enc_b_out // encoder pulse out phase b
);
    // ==========================================================
    // input synchronisers: address switch, dip 1-2, limit and encoder pins pass two flops
    logic [13:0] pin_s1_q;
    logic [13:0] pin_s2_q;
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            pin_s1_q <= 14'h0000;
            pin_s2_q <= 14'h0000;
        end else begin
            // reserved dip positions 3 and 4 carry no function
            pin_s1_q <= {enc_b_in, enc_a_in, rev_limit_in, fwd_limit_in,
                         link_option_dip[1:0], addr_low_switch,
                         addr_high_switch};
            pin_s2_q <= pin_s1_q;
        end
    end

    // encoder pulses forwarded with unchanged polarity regardless of
    // the reverse setting
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            enc_a_out <= 1'b0;
            enc_b_out <= 1'b0;
        end else begin
            enc_a_out <= pin_s2_q[12];
            enc_b_out <= pin_s2_q[13];
        end
    end

    // ==========================================================
    // limit debounce: a level must hold for the whole window
    localparam logic [10:0] DB_LAST = 11'(servo_cfg_pkg::DEBOUNCE_CYC - 1);
    logic [1:0] lim_clean_q;
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_deb
            logic [10:0] cnt_q;
            always_ff @(posedge ref_clk or negedge arst_n) begin
                if (!arst_n) begin
                    cnt_q <= 11'h000;
                    lim_clean_q[gi] <= 1'b0;
                end else if (pin_s2_q[10+gi] == lim_clean_q[gi]) begin
                    cnt_q <= 11'h000;
                end else if (cnt_q == DB_LAST) begin
                    cnt_q <= 11'h000;
                    lim_clean_q[gi] <= pin_s2_q[10+gi];
                end else begin
                    cnt_q <= cnt_q + 11'h001;
                end
            end
        end
    endgenerate

    // ==========================================================
    // power-up capture of switches; later changes are ignored
    logic [1:0] boot_cnt_q;
    logic boot_done_q;
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            boot_cnt_q <= 2'h0;
            boot_done_q <= 1'b0;
        end else if (!boot_done_q) begin
            boot_cnt_q <= boot_cnt_q + 2'h1;
            boot_done_q <= (boot_cnt_q == 2'(servo_cfg_pkg::BOOT_CYC - 1));
        end
    end
    wire logic capture = !boot_done_q &&
        (boot_cnt_q == 2'(servo_cfg_pkg::BOOT_CYC - 1));
    wire logic [7:0] addr_raw = {pin_s2_q[3:0], pin_s2_q[7:4]};

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            station_addr <= servo_cfg_pkg::ADDR_FIRST;
            station_valid <= 1'b0;
            xfer_bytes <= servo_cfg_pkg::BYTES_48;
            xfer_valid <= 1'b0;
        end else if (capture) begin
            station_addr <= addr_raw;
            station_valid <= addr_raw >= servo_cfg_pkg::ADDR_FIRST &&
                addr_raw <= servo_cfg_pkg::ADDR_LAST;
            unique case (pin_s2_q[9:8])
                2'h0: xfer_bytes <= servo_cfg_pkg::BYTES_16;
                2'h1: xfer_bytes <= servo_cfg_pkg::BYTES_32;
                2'h2: xfer_bytes <= servo_cfg_pkg::BYTES_48;
                2'h3: xfer_bytes <= 6'h00;
            endcase
            xfer_valid <= pin_s2_q[9:8] != 2'h3;
        end
    end

    // ==========================================================
    // wishbone slave, one wait state, unmapped reads give zero
    logic dir_rev_q;
    logic [3:0] fwd_sel_q;
    logic [3:0] rev_sel_q;
    logic [7:0] stop_q;
    logic [9:0] estop_q;
    logic [9:0] maxtrq_q;
    logic dir_act_q;
    logic fwd_use_q;
    logic rev_use_q;
    logic [7:0] stop_act_q;
    servo_cfg_pkg::stop_state_t st_q;
    servo_cfg_pkg::stop_state_t st_d;

    wire logic req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire logic wr = req && wb_we_i;
    wire logic wr_restart = wr && wb_adr_i == servo_cfg_pkg::CTRL_OFS &&
        wb_sel_i[0] && wb_dat_i[servo_cfg_pkg::CTRL_RESTART_BIT];
    wire logic [9:0] wr_trq = wb_dat_i[9:0] > servo_cfg_pkg::ESTOP_MAX ?
        servo_cfg_pkg::ESTOP_MAX : wb_dat_i[9:0];

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            dir_rev_q <= 1'b0;
            fwd_sel_q <= servo_cfg_pkg::FWD_SEL_RST;
            rev_sel_q <= servo_cfg_pkg::REV_SEL_RST;
            stop_q <= servo_cfg_pkg::STOP_RST;
            estop_q <= servo_cfg_pkg::ESTOP_RST;
            maxtrq_q <= servo_cfg_pkg::MAXTRQ_RST;
        end else if (wr && wb_sel_i[0]) begin
            unique case (wb_adr_i)
                servo_cfg_pkg::DIR_OFS:
                    dir_rev_q <= wb_dat_i[servo_cfg_pkg::DIR_REVERSE_BIT];
                servo_cfg_pkg::FWD_SEL_OFS: fwd_sel_q <= wb_dat_i[3:0];
                servo_cfg_pkg::REV_SEL_OFS: rev_sel_q <= wb_dat_i[3:0];
                servo_cfg_pkg::STOP_OFS: stop_q <= wb_dat_i[7:0];
                servo_cfg_pkg::ESTOP_OFS: estop_q <= wr_trq;
                servo_cfg_pkg::MAXTRQ_OFS: maxtrq_q <= wr_trq;
                default: ;
            endcase
        end
    end

    // settings marked for restart are copied at reset and on restart
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            dir_act_q <= 1'b0;
            fwd_use_q <= 1'b1;
            rev_use_q <= 1'b1;
            stop_act_q <= servo_cfg_pkg::STOP_RST;
        end else if (wr_restart) begin
            dir_act_q <= dir_rev_q;
            fwd_use_q <= fwd_sel_q != servo_cfg_pkg::SEL_IGNORE;
            rev_use_q <= rev_sel_q != servo_cfg_pkg::SEL_IGNORE;
            stop_act_q <= stop_q;
        end
    end

    // immediate, clamped to the motor's own maximum
    wire logic [9:0] trq_applied = estop_q > maxtrq_q ? maxtrq_q : estop_q;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= req;
            wb_dat_o <= 32'h0000_0000;
            if (req && !wb_we_i) begin
                unique case (wb_adr_i)
                    servo_cfg_pkg::DIR_OFS: wb_dat_o[0] <= dir_rev_q;
                    servo_cfg_pkg::FWD_SEL_OFS: wb_dat_o[3:0] <= fwd_sel_q;
                    servo_cfg_pkg::REV_SEL_OFS: wb_dat_o[3:0] <= rev_sel_q;
                    servo_cfg_pkg::STOP_OFS: wb_dat_o[7:0] <= stop_q;
                    servo_cfg_pkg::ESTOP_OFS: wb_dat_o[9:0] <= estop_q;
                    servo_cfg_pkg::MAXTRQ_OFS: wb_dat_o[9:0] <= maxtrq_q;
                    servo_cfg_pkg::STATUS_OFS: wb_dat_o[25:0] <=
                        {st_q, rev_overtravel, fwd_overtravel, xfer_valid,
                         station_valid, 2'h0, xfer_bytes, station_addr};
                    servo_cfg_pkg::ACTIVE_OFS: wb_dat_o[20:0] <=
                        {trq_applied, rev_use_q, fwd_use_q, dir_act_q,
                         stop_act_q};
                    default: ;
                endcase
            end
        end
    end

    // ==========================================================
    // overtravel and stop sequencing
    wire logic fwd_ot = fwd_use_q && !lim_clean_q[0];
    wire logic rev_ot = rev_use_q && !lim_clean_q[1];
    // only motion toward the tripped limit counts; the far way is free
    wire logic ot_hit = ref_active &&
        ((ref_fwd && fwd_ot) || (!ref_fwd && rev_ot));
    wire logic [3:0] low_dig = stop_act_q[3:0];
    wire logic [3:0] sec_dig = stop_act_q[7:4];
    wire logic use_decel = !torque_mode &&
        (sec_dig == servo_cfg_pkg::DECEL_ZCLAMP ||
         sec_dig == servo_cfg_pkg::DECEL_COAST);

    always_comb begin
        st_d = st_q;
        unique case (st_q)
            servo_cfg_pkg::ST_RUN:
                if (ot_hit) begin
                    if (use_decel)
                        st_d = servo_cfg_pkg::ST_DECEL;
                    else if (low_dig == servo_cfg_pkg::STOP_COAST)
                        st_d = servo_cfg_pkg::ST_COAST_STOP;
                    else
                        st_d = servo_cfg_pkg::ST_DB_STOP;
                end
            servo_cfg_pkg::ST_DB_STOP, servo_cfg_pkg::ST_COAST_STOP:
                if (motor_stopped)
                    st_d = servo_cfg_pkg::ST_COAST_HOLD;
            servo_cfg_pkg::ST_DECEL:
                if (motor_stopped) begin
                    if (sec_dig == servo_cfg_pkg::DECEL_ZCLAMP)
                        st_d = servo_cfg_pkg::ST_ZCLAMP;
                    else
                        st_d = servo_cfg_pkg::ST_COAST_HOLD;
                end
            servo_cfg_pkg::ST_ZCLAMP, servo_cfg_pkg::ST_COAST_HOLD:
                if (ref_active && !ot_hit)
                    st_d = servo_cfg_pkg::ST_RUN;
            default: st_d = servo_cfg_pkg::ST_COAST_HOLD;
        endcase
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n)
            st_q <= servo_cfg_pkg::ST_RUN;
        else
            st_q <= st_d;
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            motor_ccw <= 1'b0;
            motion_en <= 1'b0;
            fwd_overtravel <= 1'b0;
            rev_overtravel <= 1'b0;
            dyn_brake_on <= 1'b0;
            coast_on <= 1'b0;
            decel_on <= 1'b0;
            decel_torque <= 10'h000;
            zero_clamp_on <= 1'b0;
        end else begin
            // forward is counterclockwise unless reversed
            motor_ccw <= ref_fwd ^ dir_act_q;
            motion_en <= st_d == servo_cfg_pkg::ST_RUN && ref_active &&
                !ot_hit;
            fwd_overtravel <= fwd_ot;
            rev_overtravel <= rev_ot;
            dyn_brake_on <= st_d == servo_cfg_pkg::ST_DB_STOP;
            coast_on <= st_d == servo_cfg_pkg::ST_COAST_STOP ||
                st_d == servo_cfg_pkg::ST_COAST_HOLD;
            decel_on <= st_d == servo_cfg_pkg::ST_DECEL;
            decel_torque <= st_d == servo_cfg_pkg::ST_DECEL ?
                trq_applied : 10'h000;
            zero_clamp_on <= st_d == servo_cfg_pkg::ST_ZCLAMP;
        end
    end

    // ==========================================================
    // checks
    station_hold_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        boot_done_q |=> $stable(station_addr))
        else $error("station address changed after power-up capture");
    station_valid_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        boot_done_q && station_valid |->
        station_addr > 8'h02 && station_addr < 8'hF0)
        else $error("disabled station address reported valid");
    addr_order_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        capture |=> station_addr == {$past(pin_s2_q[3:0]),
                                     $past(pin_s2_q[7:4])})
        else $error("station address digits in wrong order");
    bytes_code_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        capture && pin_s2_q[9:8] == 2'h1 |=> xfer_bytes == 6'h20)
        else $error("dip code one must give 32 bytes");
    dir_flip_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (boot_done_q || boot_cnt_q != 2'h0) |->
        motor_ccw == ($past(ref_fwd) ^ $past(dir_act_q)))
        else $error("motor direction does not follow reverse setting");
    fwd_block_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        motion_en && ref_fwd |-> !$past(fwd_ot) || !$past(ref_fwd))
        else $error("forward motion enabled in forward overtravel");
    rev_accept_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        st_q == servo_cfg_pkg::ST_COAST_HOLD && ref_active && !ref_fwd &&
        fwd_ot && !rev_ot |=> motion_en)
        else $error("opposite reference refused during overtravel");
    torque_nodecel_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        st_q == servo_cfg_pkg::ST_RUN && ot_hit && torque_mode
        |=> !decel_on && (dyn_brake_on || coast_on))
        else $error("deceleration stop taken under torque control");
    trq_clamp_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        decel_on |-> decel_torque <= $past(maxtrq_q) &&
        decel_torque <= 10'h320)
        else $error("emergency torque above motor maximum");
    zclamp_after_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        st_q == servo_cfg_pkg::ST_DECEL && motor_stopped &&
        sec_dig == 4'h1 |=> zero_clamp_on ##0 !coast_on)
        else $error("zero clamp not entered after deceleration");
endmodule : servo_station_config_overtravel_stop

// *** test/drive_partner_model.sv ***
// behavioural model of the motor, encoder and stop feedback around the block
`timescale 1ns/1ps
module drive_partner_model #(
    parameter int STOP_CYC = 20, // cycles a braking motor needs to halt
    parameter int ENC_STEP = 16 // cycles between encoder edges
) (
    input wire logic ref_clk, // system clock
    input wire logic arst_n, // asynchronous reset
    input wire logic stopping, // brake, coast or decel output active
    output logic motor_stopped, // speed reached zero
    output logic enc_a, // encoder phase a
    output logic enc_b // encoder phase b
);
    // ==========================================================
    // stop feedback: speed falls only while a stop output is held
    int stop_cnt_q;
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            stop_cnt_q <= 0;
            motor_stopped <= 1'b0;
        end else if (!stopping) begin
            stop_cnt_q <= 0;
            motor_stopped <= 1'b0;
        end else if (stop_cnt_q < STOP_CYC) begin
            stop_cnt_q <= stop_cnt_q + 1;
        end else begin
            motor_stopped <= 1'b1;
        end
    end
    // ==========================================================
    // quadrature source, slow enough that each phase can be sampled
    int enc_cnt_q;
    logic [1:0] gray_q;
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            enc_cnt_q <= 0;
            gray_q <= 2'h0;
        end else if (enc_cnt_q == ENC_STEP - 1) begin
            enc_cnt_q <= 0;
            gray_q <= {gray_q[0], ~gray_q[1]};
        end else begin
            enc_cnt_q <= enc_cnt_q + 1;
        end
    end
    assign enc_a = gray_q[1];
    assign enc_b = gray_q[0];
endmodule : drive_partner_model

// *** test/servo_station_config_overtravel_stop_bench.sv ***
// self-checking bench for station switches, direction and overtravel stops
`timescale 1ns/1ps
module servo_station_config_overtravel_stop_bench;
    logic ref_clk, arst_n, cyc, stb, we, ack, fwd_lim, rev_lim;
    logic ref_act, ref_fwd, trq, stopped, ea, eb, ea_o, eb_o, e0;
    logic [7:0] adr, st_addr;
    logic [3:0] hi_sw, lo_sw, dip;
    logic [31:0] wdat, rdat, q;
    logic [5:0] xbytes;
    logic [9:0] dtrq;
    logic st_ok, x_ok, ccw, men, fot, rot, db, cst, dec, zc;
    int errors, tests_run, n, i;
    wire logic [3:0] stop_v = {db, cst, dec, zc};
    logic [7:0] t_adr [4] = '{8'h02, 8'hEF, 8'hF0, 8'h03};
    logic [5:0] t_by [4] = '{6'h10, 6'h20, 6'h30, 6'h00};
    logic t_av [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
    logic [7:0] s_code [5] = '{8'h00, 8'h02, 8'h10, 8'h20, 8'h10};
    logic s_trq [5] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
    logic [3:0] s_ph [5] = '{4'h8, 4'h4, 4'h2, 4'h2, 4'h8};
    logic [3:0] s_end [5] = '{4'h4, 4'h4, 4'h1, 4'h4, 4'h4};

    servo_station_config_overtravel_stop i_dut (
        .ref_clk(ref_clk), .arst_n(arst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .addr_high_switch(hi_sw),
        .addr_low_switch(lo_sw), .link_option_dip(dip),
        .fwd_limit_in(fwd_lim), .rev_limit_in(rev_lim), .enc_a_in(ea),
        .enc_b_in(eb), .ref_active(ref_act), .ref_fwd(ref_fwd),
        .torque_mode(trq), .motor_stopped(stopped), .station_addr(st_addr),
        .station_valid(st_ok), .xfer_bytes(xbytes), .xfer_valid(x_ok),
        .motor_ccw(ccw), .motion_en(men), .fwd_overtravel(fot),
        .rev_overtravel(rot), .dyn_brake_on(db), .coast_on(cst),
        .decel_on(dec), .decel_torque(dtrq), .zero_clamp_on(zc),
        .enc_a_out(ea_o), .enc_b_out(eb_o));
    drive_partner_model i_partner (.ref_clk(ref_clk), .arst_n(arst_n),
        .stopping(db | cst | dec), .motor_stopped(stopped), .enc_a(ea),
        .enc_b(eb));
    // ==========================================================
    // clock and shared tasks
    initial ref_clk = 1'b0;
    always #5 ref_clk = ~ref_clk;
    task report_and_stop();
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : report_and_stop
    task check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    // single classic cycle; waits for ack under a bound
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge ref_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        k = 0;
        do begin @(posedge ref_clk); k++; end while (ack !== 1'b1 && k < 20);
        if (k >= 20) begin errors++; report_and_stop(); end
        q = rdat;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    endtask : wb
    task boot(input logic [7:0] sw, input logic [3:0] d);
        @(posedge ref_clk);
        arst_n <= 1'b0; {hi_sw, lo_sw} <= sw; dip <= d;
        repeat (16) @(posedge ref_clk);
        arst_n <= 1'b1;
        repeat (6) @(posedge ref_clk);
    endtask : boot
    task wait_flag(input int sel_rev);
        n = 0;
        do begin @(posedge ref_clk); n++; end
        while ((sel_rev ? rot : fot) !== 1'b1 && n < 2100);
        if (n >= 2100) begin errors++; report_and_stop(); end
    endtask : wait_flag
    // ==========================================================
    // main sequence
    initial begin
        arst_n = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00;
        wdat = 32'h0; hi_sw = 4'h0; lo_sw = 4'h3; dip = 4'h2; trq = 1'b0;
        fwd_lim = 1'b1; rev_lim = 1'b1; ref_act = 1'b0; ref_fwd = 1'b1;
        errors = 0; tests_run = 0;
        // upper dip positions stay off throughout
        for (i = 0; i < 4; i++) begin
            boot(t_adr[i], i[3:0]);
            check(st_addr, t_adr[i]);
            check(st_ok, t_av[i]);
            check(xbytes, t_by[i]);
            check(x_ok, i != 3);
        end
        {hi_sw, lo_sw} <= 8'h5A; dip <= 4'h1;
        repeat (20) @(posedge ref_clk);
        check({st_addr, 2'h0, xbytes}, {8'h03, 8'h00});
        boot(8'h03, 4'h2);
        check(xbytes, 6'h30);
        wb(1'b0, servo_cfg_pkg::FWD_SEL_OFS, 0);
        check(q[3:0], 4'h1);
        wb(1'b0, servo_cfg_pkg::REV_SEL_OFS, 0);
        check(q[3:0], 4'h2);
        wb(1'b0, servo_cfg_pkg::ESTOP_OFS, 0);
        check(q[9:0], 10'h320);
        wb(1'b0, 8'h40, 0);
        check(q, 32'h0);
        // limits not yet debounced high, so both overtravel bits are set
        wb(1'b0, servo_cfg_pkg::STATUS_OFS, 0);
        check(q, 32'h001F_3003);
        wb(1'b0, servo_cfg_pkg::ACTIVE_OFS, 0);
        check(q[20:11], 10'h12C);
        wb(1'b1, servo_cfg_pkg::ESTOP_OFS, 32'h0FA);
        wb(1'b0, servo_cfg_pkg::ACTIVE_OFS, 0);
        check(q[20:11], 10'h0FA);
        wb(1'b1, servo_cfg_pkg::ESTOP_OFS, 32'h384);
        wb(1'b0, servo_cfg_pkg::ESTOP_OFS, 0);
        check(q[9:0], 10'h320);
        wb(1'b0, servo_cfg_pkg::ACTIVE_OFS, 0);
        check(q[20:11], 10'h12C);
        // direction
        repeat (3) @(posedge ref_clk);
        check(ccw, 1'b1);
        wb(1'b1, servo_cfg_pkg::DIR_OFS, 32'h1);
        wb(1'b1, servo_cfg_pkg::CTRL_OFS, 32'h1);
        repeat (3) @(posedge ref_clk);
        check(ccw, 1'b0);
        e0 = ea; n = 0;
        do begin @(posedge ref_clk); n++; end while (ea === e0 && n < 40);
        if (ea === e0) begin
            errors++;
            report_and_stop();
        end
        repeat (8) @(posedge ref_clk);
        check({ea_o, eb_o}, {ea, eb});
        wb(1'b1, servo_cfg_pkg::DIR_OFS, 32'h0);
        // overtravel: let the limits settle, then trip them
        repeat (2010) @(posedge ref_clk);
        ref_act <= 1'b1;
        rev_lim <= 1'b0;
        repeat (5) @(posedge ref_clk);
        rev_lim <= 1'b1;
        repeat (2010) @(posedge ref_clk);
        check({rot, men}, 2'b01);
        for (i = 0; i < 5; i++) begin
            wb(1'b1, servo_cfg_pkg::STOP_OFS, {24'h0, s_code[i]});
            wb(1'b1, servo_cfg_pkg::CTRL_OFS, 32'h1);
            trq <= s_trq[i]; ref_fwd <= 1'b1;
            repeat (3) @(posedge ref_clk);
            fwd_lim <= 1'b0;
            wait_flag(0);
            repeat (2) @(posedge ref_clk);
            check({men,stop_v}, {1'b0,s_ph[i]});
            check(dtrq, s_ph[i] == 4'h2 ? 10'h12C : 10'h0);
            repeat (40) @(posedge ref_clk);
            check(stop_v, s_end[i]);
            ref_fwd <= 1'b0;
            repeat (3) @(posedge ref_clk);
            check(men, 1'b1);
            fwd_lim <= 1'b1; trq <= 1'b0;
            repeat (2010) @(posedge ref_clk);
        end
        rev_lim <= 1'b0;
        wait_flag(1);
        repeat (2) @(posedge ref_clk);
        check(men, 1'b0);
        ref_fwd <= 1'b1;
        repeat (40) @(posedge ref_clk);
        check(men, 1'b1);
        rev_lim <= 1'b1;
        repeat (2010) @(posedge ref_clk);
        wb(1'b1, servo_cfg_pkg::FWD_SEL_OFS, 32'h8);
        wb(1'b1, servo_cfg_pkg::REV_SEL_OFS, 32'h8);
        wb(1'b1, servo_cfg_pkg::CTRL_OFS, 32'h1);
        fwd_lim <= 1'b0; rev_lim <= 1'b0;
        repeat (2010) @(posedge ref_clk);
        check({fot, rot, men}, 3'b001);
        report_and_stop();
    end
endmodule : servo_station_config_overtravel_stop_bench
